// file: hw/tpcr_defines.vh
// constants for the test port and configuration restore block
// assumes a 250 MHz system clock; times are converted to cycles here
`ifndef TPCR_DEFINES_VH
`define TPCR_DEFINES_VH
// instruction codes, four bits
`define TPCR_IR_W 4
`define TPCR_IR_EXTEST 4'h0
`define TPCR_IR_SAMPLE 4'h1
`define TPCR_IR_IDCODE 4'h2
`define TPCR_IR_WRITE 4'h4
`define TPCR_IR_READ 4'h5
`define TPCR_IR_STORE 4'h6
`define TPCR_IR_RELOAD 4'h7
`define TPCR_IR_CLAMP 4'h8
`define TPCR_IR_HIGHZ 4'h9
`define TPCR_IR_BYPASS 4'hF
// programming path layout
`define TPCR_CFG_W 96
`define TPCR_PATH_W 112
`define TPCR_RSVD_W 16
`define TPCR_RSVD_VAL 16'h0000
`define TPCR_BSR_W 13
// timing: clock period and restore / store times
`define TPCR_CLK_NS 4
`define TPCR_RESTORE_US 3000
`define TPCR_RESTORE_CYC ((`TPCR_RESTORE_US * 1000) / `TPCR_CLK_NS)
`define TPCR_STORE_US 3000
`define TPCR_STORE_CYC ((`TPCR_STORE_US * 1000) / `TPCR_CLK_NS)
`define TPCR_CNT_W 24
`endif

// file: hw/tpcr_top.v
// test access port with configuration store, reload and power-up restore
// assumes tck, tms, tdi and power_down_n arrive asynchronously; all are
// synchronised and tck edges are found on clk_sys (tck far below clk_sys)
`timescale 1ns/1ps
`include "tpcr_defines.vh"
module tpcr_top #(
	parameter RESTORE_CYC = `TPCR_RESTORE_CYC,
	parameter STORE_CYC = `TPCR_STORE_CYC
) (
	// system
	input wire clk_sys,
	input wire rst,
	// test port pins
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo_ff,
	output reg tdo_oe_ff,
	// device pins
	input wire power_down_n,
	input wire [4:0] bank_output_enable_n,
	input wire output_stop_level_select,
	input wire min_freq_clk,
	input wire pll_locked_in,
	// nonvolatile memory image
	input wire [`TPCR_CFG_W-1:0] nvm_data,
	output reg [`TPCR_CFG_W-1:0] nvm_wdata_ff,
	output reg nvm_write_ff,
	// configuration and status
	output reg [`TPCR_CFG_W-1:0] config_ff,
	output reg restore_done_ff,
	output reg nvm_busy_ff,
	output reg relock_req_ff,
	output reg pll_lock_ff,
	output reg pll_min_freq_ff,
	output reg [`TPCR_IR_W-1:0] instr_ff,
	// clock outputs, with enables for high impedance
	output reg [9:0] bank_clock_outputs_ff,
	output reg bank_oe_ff,
	output reg [1:0] feedback_clock_output_ff,
	output reg fb_oe_ff
);
	// tap states
	localparam S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3;
	localparam S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PAU_DR = 4'h6, S_EX2_DR = 4'h7;
	localparam S_UPD_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'hA, S_SH_IR = 4'hB;
	localparam S_EX1_IR = 4'hC, S_PAU_IR = 4'hD, S_EX2_IR = 4'hE, S_UPD_IR = 4'hF;
	// memory engine states
	localparam M_POR = 2'h0, M_IDLE = 2'h1, M_LOAD = 2'h2, M_STORE = 2'h3;

	// next tap state for a given tms
	function [3:0] tap_next;
		input [3:0] s;
		input t;
		begin
			case (s)
				S_RESET: tap_next = t ? S_RESET : S_IDLE;
				S_IDLE: tap_next = t ? S_SEL_DR : S_IDLE;
				S_SEL_DR: tap_next = t ? S_SEL_IR : S_CAP_DR;
				S_CAP_DR: tap_next = t ? S_EX1_DR : S_SH_DR;
				S_SH_DR: tap_next = t ? S_EX1_DR : S_SH_DR;
				S_EX1_DR: tap_next = t ? S_UPD_DR : S_PAU_DR;
				S_PAU_DR: tap_next = t ? S_EX2_DR : S_PAU_DR;
				S_EX2_DR: tap_next = t ? S_UPD_DR : S_SH_DR;
				S_UPD_DR: tap_next = t ? S_SEL_DR : S_IDLE;
				S_SEL_IR: tap_next = t ? S_RESET : S_CAP_IR;
				S_CAP_IR: tap_next = t ? S_EX1_IR : S_SH_IR;
				S_SH_IR: tap_next = t ? S_EX1_IR : S_SH_IR;
				S_EX1_IR: tap_next = t ? S_UPD_IR : S_PAU_IR;
				S_PAU_IR: tap_next = t ? S_EX2_IR : S_PAU_IR;
				S_EX2_IR: tap_next = t ? S_UPD_IR : S_SH_IR;
				S_UPD_IR: tap_next = t ? S_SEL_DR : S_IDLE;
				default: tap_next = S_RESET;
			endcase
		end
	endfunction

	// true for the programming codes write, read, store, reload
	function is_prog;
		input [3:0] c;
		begin
			is_prog = (c[3:2] == 2'b01);
		end
	endfunction

	// pin synchronisers; first stages read only by second stages
	reg [3:0] sync1_ff;
	reg [3:0] sync2_ff;
	reg tck_prev_ff; // last synchronised tck, for edge finding
	reg mf1_ff; // min-frequency clock synchroniser
	reg mf2_ff;
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
			tck_prev_ff <= 1'b0;
			mf1_ff <= 1'b0;
			mf2_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= {power_down_n, tdi, tms, tck};
			sync2_ff <= sync1_ff;
			tck_prev_ff <= sync2_ff[0];
			mf1_ff <= min_freq_clk;
			mf2_ff <= mf1_ff;
		end
	end
	wire tck_s = sync2_ff[0];
	wire tms_s = sync2_ff[1];
	wire tdi_s = sync2_ff[2];
	wire pd_n_s = sync2_ff[3];
	wire tck_rise = tck_s & ~tck_prev_ff;
	wire tck_fall = ~tck_s & tck_prev_ff;

	// tap registers
	reg [3:0] tap_ff; // controller state
	reg [3:0] ir_sh_ff; // instruction shift stage
	reg byp_ff; // one-bit bypass register
	reg [`TPCR_PATH_W-1:0] prog_sh_ff; // programming path
	reg [`TPCR_BSR_W-1:0] bsr_sh_ff; // boundary shift stage
	reg [`TPCR_BSR_W-1:0] bsr_upd_ff; // boundary update stage
	reg [1:0] mem_st_ff; // memory engine state
	reg [`TPCR_CNT_W-1:0] mem_cnt_ff; // memory operation timer
	reg load_pulse_ff; // config loaded this cycle
	reg write_pulse_ff; // write instruction update
	reg start_store_ff; // store request from tap
	reg start_load_ff; // reload request from tap

	// path selection by current instruction
	wire sel_prog = (instr_ff == `TPCR_IR_WRITE) || (instr_ff == `TPCR_IR_READ);
	wire sel_bsr = (instr_ff == `TPCR_IR_EXTEST) || (instr_ff == `TPCR_IR_SAMPLE);
	wire sh_dr = (tap_ff == S_SH_DR);
	wire sh_ir = (tap_ff == S_SH_IR);

	// tap controller, shifting on rising tck
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			tap_ff <= S_RESET;
			ir_sh_ff <= 4'h0;
			instr_ff <= `TPCR_IR_BYPASS;
			byp_ff <= 1'b0;
			prog_sh_ff <= {`TPCR_PATH_W{1'b0}};
			bsr_sh_ff <= {`TPCR_BSR_W{1'b0}};
			bsr_upd_ff <= {`TPCR_BSR_W{1'b0}};
			write_pulse_ff <= 1'b0;
			start_store_ff <= 1'b0;
			start_load_ff <= 1'b0;
		end
		else
		begin
			write_pulse_ff <= 1'b0;
			start_store_ff <= 1'b0;
			start_load_ff <= 1'b0;
			if (tck_rise)
			begin
				tap_ff <= tap_next(tap_ff, tms_s);
				case (tap_ff)
					S_RESET:
						instr_ff <= `TPCR_IR_BYPASS;
					S_CAP_IR:
						ir_sh_ff <= 4'h1;
					S_SH_IR:
						ir_sh_ff <= {tdi_s, ir_sh_ff[3:1]};
					S_UPD_IR:
					begin
						// programming code refused while memory busy
						if (is_prog(ir_sh_ff) && mem_st_ff != M_IDLE)
							instr_ff <= `TPCR_IR_BYPASS;
						else
							instr_ff <= ir_sh_ff;
						if (mem_st_ff == M_IDLE && ir_sh_ff == `TPCR_IR_STORE)
							start_store_ff <= 1'b1;
						if (mem_st_ff == M_IDLE && ir_sh_ff == `TPCR_IR_RELOAD)
							start_load_ff <= 1'b1;
					end
					S_CAP_DR:
					begin
						byp_ff <= 1'b0;
						if (sel_prog)
							prog_sh_ff <= {`TPCR_RSVD_VAL, config_ff};
						if (sel_bsr)
							bsr_sh_ff <= {bank_clock_outputs_ff, feedback_clock_output_ff,
								pll_lock_ff};
					end
					S_SH_DR:
					begin
						// clamp, highz and bypass all use the one-bit path
						byp_ff <= tdi_s;
						if (sel_prog)
							prog_sh_ff <= {tdi_s, prog_sh_ff[`TPCR_PATH_W-1:1]};
						if (sel_bsr)
							bsr_sh_ff <= {tdi_s, bsr_sh_ff[`TPCR_BSR_W-1:1]};
					end
					S_UPD_DR:
					begin
						if (instr_ff == `TPCR_IR_WRITE)
							write_pulse_ff <= 1'b1;
						if (sel_bsr)
							bsr_upd_ff <= bsr_sh_ff;
					end
					default:
						byp_ff <= byp_ff;
				endcase
			end
		end
	end

	// tdo changes on falling tck, driven only while shifting
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			tdo_ff <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo_oe_ff <= sh_dr | sh_ir;
			if (sh_ir)
				tdo_ff <= ir_sh_ff[0];
			else if (sel_prog)
				tdo_ff <= prog_sh_ff[0];
			else if (sel_bsr)
				tdo_ff <= bsr_sh_ff[0];
			else
				tdo_ff <= byp_ff;
		end
	end

	// memory engine: power-up restore, reload and store
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			mem_st_ff <= M_POR;
			mem_cnt_ff <= {`TPCR_CNT_W{1'b0}};
			config_ff <= {`TPCR_CFG_W{1'b0}};
			restore_done_ff <= 1'b0;
			nvm_busy_ff <= 1'b1;
			nvm_wdata_ff <= {`TPCR_CFG_W{1'b0}};
			nvm_write_ff <= 1'b0;
			load_pulse_ff <= 1'b0;
		end
		else
		begin
			load_pulse_ff <= 1'b0;
			nvm_write_ff <= 1'b0;
			if (write_pulse_ff && mem_st_ff == M_IDLE)
			begin
				config_ff <= prog_sh_ff[`TPCR_CFG_W-1:0];
				load_pulse_ff <= 1'b1;
			end
			case (mem_st_ff)
				M_POR, M_LOAD:
				begin
					// timer holds while power is down; pll enable not looked at
					if (pd_n_s)
						mem_cnt_ff <= mem_cnt_ff + 1'b1;
					if (pd_n_s && mem_cnt_ff >= RESTORE_CYC[`TPCR_CNT_W-1:0] - 1'b1)
					begin
						config_ff <= nvm_data;
						load_pulse_ff <= 1'b1;
						restore_done_ff <= 1'b1;
						nvm_busy_ff <= 1'b0;
						mem_st_ff <= M_IDLE;
					end
				end
				M_STORE:
				begin
					mem_cnt_ff <= mem_cnt_ff + 1'b1;
					if (mem_cnt_ff >= STORE_CYC[`TPCR_CNT_W-1:0] - 1'b1)
					begin
						nvm_wdata_ff <= config_ff;
						nvm_write_ff <= 1'b1;
						nvm_busy_ff <= 1'b0;
						mem_st_ff <= M_IDLE;
					end
				end
				default:
				begin
					mem_cnt_ff <= {`TPCR_CNT_W{1'b0}};
					if (start_load_ff)
					begin
						nvm_busy_ff <= 1'b1;
						mem_st_ff <= M_LOAD;
					end
					else if (start_store_ff && pd_n_s)
					begin
						nvm_busy_ff <= 1'b1;
						mem_st_ff <= M_STORE;
					end
				end
			endcase
		end
	end

	// pll status: relock request and lock gated by restore
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			relock_req_ff <= 1'b0;
			pll_lock_ff <= 1'b0;
			pll_min_freq_ff <= 1'b1;
		end
		else
		begin
			relock_req_ff <= load_pulse_ff;
			pll_min_freq_ff <= ~restore_done_ff;
			pll_lock_ff <= restore_done_ff & pll_locked_in;
		end
	end

	// output stage: clamp, high impedance, pre-restore and normal
	// the pre-restore clock on enabled banks is the sampled minimum-frequency clock; feedback holds 01
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			bank_clock_outputs_ff <= 10'h000;
			bank_oe_ff <= 1'b0;
			feedback_clock_output_ff <= 2'h0;
			fb_oe_ff <= 1'b0;
		end
		else if (instr_ff == `TPCR_IR_HIGHZ)
		begin
			bank_oe_ff <= 1'b0;
			fb_oe_ff <= 1'b0;
		end
		else if (instr_ff == `TPCR_IR_CLAMP || instr_ff == `TPCR_IR_EXTEST)
		begin
			// outputs follow boundary update stage, not the shifting stage
			bank_clock_outputs_ff <= bsr_upd_ff[`TPCR_BSR_W-1:3];
			feedback_clock_output_ff <= bsr_upd_ff[2:1];
			bank_oe_ff <= 1'b1;
			fb_oe_ff <= 1'b1;
		end
		else
		begin
			// normal function, also under bypass
			bank_oe_ff <= 1'b1;
			fb_oe_ff <= 1'b1;
			feedback_clock_output_ff <= {~mf2_ff, mf2_ff};
			if (!restore_done_ff && !output_stop_level_select)
				feedback_clock_output_ff <= 2'b01;
			else if (!restore_done_ff)
				feedback_clock_output_ff <= 2'b01;
			bank_clock_outputs_ff <= 10'h000;
			begin : banks
				integer i;
				for (i = 0; i < 5; i = i + 1)
					if (!bank_output_enable_n[i])
						bank_clock_outputs_ff[2*i +: 2] <= {mf2_ff, mf2_ff};
					else if (output_stop_level_select)
						bank_clock_outputs_ff[2*i +: 2] <= 2'b11;
			end
		end
	end
endmodule

// file: tb/tpcr_sva.sv
// checker for the test port and configuration restore block
// assumes it is bound to tpcr_top, one clock domain
`timescale 1ns/1ps
module tpcr_sva #(
	parameter RESTORE_CYC = 2000
) (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// device pins
	input wire power_down_n,
	input wire [4:0] bank_output_enable_n,
	input wire output_stop_level_select,
	// status
	input wire [95:0] config_ff,
	input wire restore_done_ff,
	input wire nvm_busy_ff,
	input wire relock_req_ff,
	input wire pll_lock_ff,
	input wire pll_min_freq_ff,
	input wire [3:0] instr_ff,
	// clock outputs
	input wire [9:0] bank_clock_outputs_ff,
	input wire bank_oe_ff,
	input wire [1:0] feedback_clock_output_ff
);
	integer up_cnt_ff; // powered cycles before restore ends
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// timer pauses in power down, so count only powered cycles
	always @(posedge clk_sys or posedge rst)
		if (rst)
			up_cnt_ff <= 0;
		else if (!restore_done_ff && power_down_n)
			up_cnt_ff <= up_cnt_ff + 1;
	sequence s_highz; (instr_ff == 4'h9)[*2]; endsequence
	sequence s_clamp; (instr_ff == 4'h8)[*3]; endsequence
	sequence s_stop;
		(power_down_n && !restore_done_ff && bank_output_enable_n == 5'h1F
			&& output_stop_level_select && instr_ff == 4'hF)[*3];
	endsequence
	sequence s_norm; (restore_done_ff && instr_ff == 4'hF && bank_output_enable_n == 5'h00)[*3];
	endsequence
	property p_cfg_zero; !restore_done_ff |-> config_ff == 96'h0; endproperty
	a_cfg_zero: assert property (p_cfg_zero) else $error("config not zero");
	property p_no_lock; !restore_done_ff |-> !pll_lock_ff && pll_min_freq_ff; endproperty
	a_no_lock: assert property (p_no_lock) else $error("lock before restore");
	property p_len; $rose(restore_done_ff) |-> up_cnt_ff >= RESTORE_CYC - 6
		&& up_cnt_ff <= RESTORE_CYC + 6; endproperty
	a_len: assert property (p_len) else $error("restore length wrong");
	property p_relock; (restore_done_ff && $past(restore_done_ff) && $changed(config_ff))
		|-> ##[0:3] relock_req_ff; endproperty
	a_relock: assert property (p_relock) else $error("no relock request");
	property p_refuse; (nvm_busy_ff && $past(nvm_busy_ff) && $changed(instr_ff))
		|-> instr_ff[3:2] != 2'b01; endproperty
	a_refuse: assert property (p_refuse) else $error("program code taken busy");
	property p_highz; s_highz |-> !bank_oe_ff; endproperty
	a_highz: assert property (p_highz) else $error("outputs driven in highz");
	property p_clamp; s_clamp |-> $stable(bank_clock_outputs_ff)
		&& $stable(feedback_clock_output_ff); endproperty
	a_clamp: assert property (p_clamp) else $error("clamped outputs moved");
	property p_stop; s_stop |-> bank_clock_outputs_ff == 10'h3FF
		&& feedback_clock_output_ff == 2'b01; endproperty
	a_stop: assert property (p_stop) else $error("stop levels wrong");
	property p_norm; s_norm |-> bank_oe_ff; endproperty
	a_norm: assert property (p_norm) else $error("bypass disturbed outputs");
endmodule
bind tpcr_top tpcr_sva #(.RESTORE_CYC(RESTORE_CYC)) u_sva (.clk_sys(clk_sys), .rst(rst),
	.power_down_n(power_down_n), .bank_output_enable_n(bank_output_enable_n),
	.output_stop_level_select(output_stop_level_select), .config_ff(config_ff),
	.restore_done_ff(restore_done_ff), .nvm_busy_ff(nvm_busy_ff),
	.relock_req_ff(relock_req_ff), .pll_lock_ff(pll_lock_ff),
	.pll_min_freq_ff(pll_min_freq_ff), .instr_ff(instr_ff),
	.bank_clock_outputs_ff(bank_clock_outputs_ff), .bank_oe_ff(bank_oe_ff),
	.feedback_clock_output_ff(feedback_clock_output_ff));

// file: tb/tpcr_host.sv
// boundary-scan host model driving the test port
// assumes tck far slower than clk_sys; tck idles low between frames
`timescale 1ns/1ps
module tpcr_host (
	// timing reference
	input wire clk_sys,
	// test port
	input wire tdo_pin,
	output reg tck,
	output reg tms,
	output reg tdi
);
	// idle: tck still, tap held towards reset
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// half tck period, 40 ns, launched just after a clk_sys edge
	task half;
		begin
			repeat (10) @(posedge clk_sys);
			#1;
		end
	endtask
	// one tck cycle; tdo taken at the rising edge
	task step(input b_tms, input b_tdi, output b_tdo);
		begin
			tms = b_tms;
			tdi = b_tdi;
			half;
			tck = 1'b1;
			b_tdo = tdo_pin;
			half;
			tck = 1'b0;
		end
	endtask
	// five highs reach test-logic-reset, then idle
	task tap_reset;
		reg d;
		integer i;
		begin
			for (i = 0; i < 6; i = i + 1)
				step(i < 5, 1'b0, d);
		end
	endtask
	// idle to shift, n bits lsb first, update, back to idle
	task shift(input is_ir, input [111:0] din, input integer n, output [111:0] dout);
		reg d;
		integer i;
		begin
			step(1'b1, 1'b0, d);
			if (is_ir)
				step(1'b1, 1'b0, d);
			step(1'b0, 1'b0, d);
			step(1'b0, 1'b0, d);
			dout = 112'h0;
			for (i = 0; i < n; i = i + 1)
			begin
				step(i == n - 1, din[i], d);
				dout[i] = d;
			end
			step(1'b1, 1'b0, d);
			step(1'b0, 1'b0, d);
		end
	endtask
endmodule

// file: tb/test_test_port_config_restore.sv
// self-checking bench for the test port and restore block
// assumes the host model on the port and a fixed memory image
`timescale 1ns/1ps
`include "tpcr_defines.vh"
`define CHK(nm, e, g) \
begin checks_done = checks_done + 1; if ((g) !== (e)) begin n_errors = n_errors + 1; \
$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module test_test_port_config_restore;
	localparam [95:0] NVM_IMG = 96'h0123_4567_0200_0000_89AB_CDEF; // bit 57 set
	localparam [95:0] WR_PAT = 96'h5A5A_F00F_1234_8765_C3C3_0FF0;
	reg clk_sys = 1'b0;
	reg rst = 1'b1;
	reg power_down_n = 1'b0;
	reg [4:0] bank_output_enable_n = 5'h1F;
	reg min_freq_clk = 1'b0;
	integer n_errors = 0, checks_done = 0, n_relock = 0, cycles = 0, n_store = 0;
	reg [95:0] stored = 96'h0; // last image handed to the memory
	wire [95:0] nvm_wdata_ff;
	wire nvm_write_ff;
	wire tck, tms, tdi, tdo_ff, tdo_oe_ff, restore_done_ff, nvm_busy_ff, relock_req_ff;
	wire pll_lock_ff, pll_min_freq_ff, bank_oe_ff, fb_oe_ff;
	wire [95:0] config_ff;
	wire [3:0] instr_ff;
	wire [9:0] bank_clock_outputs_ff;
	wire [1:0] feedback_clock_output_ff;
	// released tdo shows the inverse of its last value
	wire tdo_pin = tdo_oe_ff ? tdo_ff : ~tdo_ff;
	tpcr_top #(.RESTORE_CYC(2000), .STORE_CYC(1500)) u_dut (.clk_sys(clk_sys), .rst(rst),
		.tck(tck), .tms(tms), .tdi(tdi), .tdo_ff(tdo_ff), .tdo_oe_ff(tdo_oe_ff),
		.power_down_n(power_down_n), .bank_output_enable_n(bank_output_enable_n),
		.output_stop_level_select(1'b1), .min_freq_clk(min_freq_clk),
		.pll_locked_in(1'b1), .nvm_data(NVM_IMG), .nvm_wdata_ff(nvm_wdata_ff),
		.nvm_write_ff(nvm_write_ff),
		.config_ff(config_ff), .restore_done_ff(restore_done_ff), .nvm_busy_ff(nvm_busy_ff),
		.relock_req_ff(relock_req_ff), .pll_lock_ff(pll_lock_ff),
		.pll_min_freq_ff(pll_min_freq_ff), .instr_ff(instr_ff),
		.bank_clock_outputs_ff(bank_clock_outputs_ff), .bank_oe_ff(bank_oe_ff),
		.feedback_clock_output_ff(feedback_clock_output_ff), .fb_oe_ff(fb_oe_ff));
	tpcr_host u_host (.clk_sys(clk_sys), .tdo_pin(tdo_pin), .tck(tck), .tms(tms), .tdi(tdi));
	always #2 clk_sys = ~clk_sys;
	// slow stand-in for the pll minimum frequency
	always
	begin
		repeat (8) @(posedge clk_sys);
		#1 min_freq_clk = ~min_freq_clk;
	end
	// relock pulses and hang guard
	always @(posedge clk_sys)
	begin
		if (relock_req_ff === 1'b1)
			n_relock = n_relock + 1;
		// memory write pulses and the data they carry
		if (nvm_write_ff === 1'b1)
		begin
			n_store = n_store + 1;
			stored = nvm_wdata_ff;
		end
		cycles = cycles + 1;
		if (cycles == 40000)
		begin
			n_errors = n_errors + 1;
			final_report;
		end
	end
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk_sys);
			#1;
		end
	endtask
	task ir(input [3:0] c);
		reg [111:0] q;
		begin
			u_host.shift(1'b1, {108'h0, c}, 4, q);
			tick(4);
		end
	endtask
	// power down stalls restore; early outputs; early program refused
	task t_early;
		integer i, n;
		reg b;
		begin
			tick(2500);
			`CHK("done in power down", 1'b0, restore_done_ff)
			power_down_n = 1'b1;
			tick(8);
			`CHK("config early", 96'h0, config_ff)
			`CHK("lock early", 1'b0, pll_lock_ff)
			`CHK("min freq", 1'b1, pll_min_freq_ff)
			`CHK("stopped banks", 10'h3FF, bank_clock_outputs_ff)
			`CHK("stopped fb", 2'b01, feedback_clock_output_ff)
			bank_output_enable_n = 5'h00;
			n = 0;
			b = bank_clock_outputs_ff[0];
			for (i = 0; i < 64; i = i + 1)
			begin
				tick(1);
				n = n + (bank_clock_outputs_ff[0] !== b);
				b = bank_clock_outputs_ff[0];
			end
			`CHK("early toggles", 1'b1, n >= 4)
			ir(`TPCR_IR_WRITE);
			`CHK("refused in restore", 4'hF, instr_ff)
			for (i = 0; i < 3000 && restore_done_ff !== 1'b1; i = i + 1)
				tick(1);
			`CHK("restore done", 1'b1, restore_done_ff)
			`CHK("restored image", NVM_IMG, config_ff)
			tick(2);
			`CHK("lock after restore", 1'b1, pll_lock_ff)
			`CHK("min freq released", 1'b0, pll_min_freq_ff)
		end
	endtask
	// write, then read back with reserved tail
	task t_write;
		reg [111:0] q;
		integer r;
		begin
			r = n_relock;
			ir(`TPCR_IR_WRITE);
			u_host.shift(1'b0, {16'hFFFF, WR_PAT}, 112, q);
			tick(4);
			`CHK("written", WR_PAT, config_ff)
			`CHK("relock write", r + 1, n_relock)
			ir(`TPCR_IR_READ);
			u_host.shift(1'b0, 112'h0, 112, q);
			`CHK("read back", WR_PAT, q[95:0])
			`CHK("reserved", `TPCR_RSVD_VAL, q[111:96])
		end
	endtask
	// store hands the written image to the memory once its timer ends
	task t_store;
		integer i;
		begin
			ir(`TPCR_IR_STORE);
			`CHK("store busy", 1'b1, nvm_busy_ff)
			for (i = 0; i < 3000 && nvm_busy_ff !== 1'b0; i = i + 1)
				tick(1);
			tick(2);
			`CHK("store pulses", 1, n_store)
			`CHK("stored image", WR_PAT, stored)
		end
	endtask
	// reload with a write attempted meanwhile
	task t_reload;
		reg [111:0] q;
		integer r, i;
		begin
			r = n_relock;
			ir(`TPCR_IR_RELOAD);
			`CHK("busy", 1'b1, nvm_busy_ff)
			ir(`TPCR_IR_WRITE);
			`CHK("refused", 4'hF, instr_ff)
			u_host.shift(1'b0, 112'h1, 2, q);
			`CHK("bypass kept", 2'b10, q[1:0])
			for (i = 0; i < 3000 && nvm_busy_ff !== 1'b0; i = i + 1)
				tick(1);
			tick(4);
			`CHK("reload ends", 1'b0, nvm_busy_ff)
			`CHK("reloaded", NVM_IMG, config_ff)
			`CHK("relock reload", r + 1, n_relock)
		end
	endtask
	// clamp, highz, bypass: one-bit path and output enables
	task t_modes;
		reg [111:0] q;
		reg [3:0] c;
		integer k;
		begin
			for (k = 0; k < 3; k = k + 1)
			begin
				c = k == 0 ? `TPCR_IR_CLAMP : k == 1 ? `TPCR_IR_HIGHZ : `TPCR_IR_BYPASS;
				ir(c);
				`CHK("mode", c, instr_ff)
				`CHK("bank enable", k != 1, bank_oe_ff)
				`CHK("fb enable", k != 1, fb_oe_ff)
				u_host.shift(1'b0, 112'h1, 2, q);
				`CHK("one-bit path", 2'b10, q[1:0])
				`CHK("tdo released", 1'b0, tdo_oe_ff)
			end
		end
	endtask
	task final_report;
		begin
			if (n_errors == 0 && checks_done > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial
	begin
		tick(8);
		rst = 1'b0;
		u_host.tap_reset;
		t_early;
		t_write;
		t_store;
		t_reload;
		t_modes;
		final_report;
	end
endmodule
